// >>> design/ttc_decoder.sv
// top of the three-tone code decoder: apb registers, modes, strobe, output
// assumes tone symbols and mode pins are synchronous to ref_clk_i and that
// open mode pins are pulled to 1 outside the block
`include "ttc_map.svh"
`timescale 1ns/100ps

module ttc_decoder
#(
   parameter logic [23:0] GATE_CYC = 24'(`TTC_GATE_CYC),
   parameter logic [15:0] TPER_CYC = 16'(`TTC_TPER_CYC)
)
(
   input wire logic ref_clk_i,
   input wire logic nrst_i,
   input wire ttc_pkg::ttc_tone_t tone_i,
   input wire logic mode1_i,
   input wire logic mode2_i,
   input wire logic [7:0] paddr_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   output ttc_pkg::ttc_code_t code_o,
   output logic code_rx_n_o,
   output logic irq_o
);
   import ttc_pkg::*;

   ttc_code_if cif();

   // ==========================================
   // register storage
   logic [1:0] mode_sw;
   logic [1:0] status;
   logic [1:0] mask;
   logic [23:0] gate_len;
   logic [15:0] tper [3];

   // ==========================================
   // datapath state
   ttc_mode_t mode;
   logic latched;
   ttc_code_t pend_code;
   logic [16:0] strobe_cnt;
   logic strobe_end;
   logic upd_evt;
   logic [1:0] set_evt;

   // ==========================================
   // bus decode
   logic acc;
   logic wr_en;
   logic [31:0] next_rdata;
   logic next_err;

   // ==========================================
   // offset decode shared by reads and writes
   function automatic logic ttc_hit(input logic [7:0] a);
      ttc_hit = (a == `TTC_OFS_CTRL) || (a == `TTC_OFS_STATUS)
         || (a == `TTC_OFS_MASK) || (a == `TTC_OFS_OUT)
         || (a == `TTC_OFS_GATE) || (a == `TTC_OFS_TPER1)
         || (a == `TTC_OFS_TPER2) || (a == `TTC_OFS_TPER3);
   endfunction

   // ==========================================
   // tone index into the period table
   function automatic logic [1:0] ttc_tidx(input ttc_tone_t t);
      ttc_tidx = (t == 2'h0) ? 2'h0 : t - 2'h1;
   endfunction

   ttc_seq_collect u_collect
   (
      .ref_clk_i(ref_clk_i),
      .nrst_i(nrst_i),
      .tone_i(tone_i),
      .cif(cif.src)
   );

   assign cif.gate_len = gate_len;

   // ==========================================
   // apb handshake: one wait state, answer registered
   assign acc = psel_i && penable_i;
   assign wr_en = acc && pready_o && pwrite_i;

   always_ff @(posedge ref_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         pready_o <= 1'b0;
      else
         pready_o <= acc && !pready_o;
   end

   always_comb
   begin
      next_rdata = 32'h0;
      next_err = !ttc_hit(paddr_i);
      unique case (paddr_i)
         `TTC_OFS_CTRL: next_rdata[1:0] = mode_sw;
         `TTC_OFS_STATUS: next_rdata[1:0] = status;
         `TTC_OFS_MASK: next_rdata[1:0] = mask;
         `TTC_OFS_OUT:
         begin
            next_rdata[2:0] = code_o;
            next_rdata[`TTC_OUT_LATCH] = latched;
            next_rdata[`TTC_OUT_MODE +: 2] = mode;
         end
         `TTC_OFS_GATE: next_rdata[23:0] = gate_len;
         `TTC_OFS_TPER1: next_rdata[15:0] = tper[0];
         `TTC_OFS_TPER2: next_rdata[15:0] = tper[1];
         `TTC_OFS_TPER3: next_rdata[15:0] = tper[2];
         default: next_rdata = 32'h0;
      endcase
   end

   always_ff @(posedge ref_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         prdata_o <= 32'h0;
         pslverr_o <= 1'b0;
      end
      else if (acc && !pready_o)
      begin
         prdata_o <= pwrite_i ? 32'h0 : next_rdata;
         pslverr_o <= next_err;
      end
      else
      begin
         prdata_o <= 32'h0;
         pslverr_o <= 1'b0;
      end
   end

   // ==========================================
   // configuration registers
   always_ff @(posedge ref_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         mode_sw <= `TTC_RST_MODE;
         mask <= 2'h0;
         gate_len <= 24'h0;
      end
      else if (wr_en)
      begin
         if (paddr_i == `TTC_OFS_CTRL)
            mode_sw <= pwdata_i[1:0];
         if (paddr_i == `TTC_OFS_MASK)
            mask <= pwdata_i[1:0];
         if (paddr_i == `TTC_OFS_GATE)
            gate_len <= pwdata_i[23:0];
      end
   end

   // the tone periods start at zero; loaded with TPER_CYC after release so a
   // parameter, not a port, sets them and the reset branch stays constant
   logic cfg_init;

   always_ff @(posedge ref_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         cfg_init <= 1'b1;
      else
         cfg_init <= 1'b0;
   end

   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++)
      begin : g_tper
         always_ff @(posedge ref_clk_i or negedge nrst_i)
         begin
            if (!nrst_i)
               tper[gi] <= 16'h0;
            else if (cfg_init)
               tper[gi] <= TPER_CYC;
            else if (wr_en && (paddr_i == 8'(`TTC_OFS_TPER1 + 4 * gi)))
               tper[gi] <= pwdata_i[15:0];
         end
      end
   endgenerate

   // ==========================================
   // mode pins sampled every cycle; open pins read 1, software can only clear
   always_ff @(posedge ref_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         mode <= TTC_M_RESET;
      else
         mode <= ttc_mode_t'({mode1_i, mode2_i} & mode_sw);
   end

   // ==========================================
   // strobe timing: low for twice the third tone period
   assign strobe_end = !code_rx_n_o && (strobe_cnt == 17'h1);

   always_ff @(posedge ref_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         code_rx_n_o <= 1'b1;
         strobe_cnt <= 17'h0;
         pend_code <= 3'h0;
      end
      else if (code_rx_n_o && cif.code_valid)
      begin
         code_rx_n_o <= 1'b0;
         strobe_cnt <= {tper[ttc_tidx(cif.tone3)], 1'b0};
         pend_code <= cif.code;
      end
      else if (!code_rx_n_o)
      begin
         if (strobe_cnt <= 17'h1)
            code_rx_n_o <= 1'b1;
         strobe_cnt <= strobe_cnt - 17'h1;
      end
   end

   // ==========================================
   // output code under the four modes
   always_ff @(posedge ref_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         code_o <= `TTC_RST_CODE;
      else if (mode == TTC_M_RESET)
         code_o <= `TTC_RST_CODE;
      else if (strobe_end)
      begin
         if (mode == TTC_M_UPDATE)
            code_o <= pend_code;
         else if (mode == TTC_M_NEXT && !latched)
            code_o <= pend_code;
      end
   end

   // latch-to-next freezes after the code that arrives next, repeat included
   always_ff @(posedge ref_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         latched <= 1'b0;
      else if (mode != TTC_M_NEXT)
         latched <= 1'b0;
      else if (strobe_end)
         latched <= 1'b1;
   end

   // hold mode needs no state: no path above writes code_o in it
   assign upd_evt = strobe_end && (pend_code != code_o)
      && ((mode == TTC_M_UPDATE) || (mode == TTC_M_NEXT && !latched));

   // ==========================================
   // interrupt status, write one to clear; a new event beats the clear
   assign set_evt[`TTC_ST_RX] = strobe_end;
   assign set_evt[`TTC_ST_UPD] = upd_evt;

   always_ff @(posedge ref_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         status <= 2'h0;
      else if (wr_en && (paddr_i == `TTC_OFS_STATUS))
         status <= (status & ~pwdata_i[1:0]) | set_evt;
      else
         status <= status | set_evt;
   end

   // one cycle behind the status bit so the pin stays a flop
   always_ff @(posedge ref_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         irq_o <= 1'b0;
      else
         irq_o <= |(status & mask);
   end

endmodule

// >>> design/ttc_map.svh
// constants of the three-tone code decoder: offsets, fields, resets, times
// assumes a 25 MHz reference clock and a 32-bit apb register window
`ifndef TTC_MAP_SVH
`define TTC_MAP_SVH

// ==========================================
// register offsets (byte addresses)
`define TTC_OFS_CTRL 8'h00
`define TTC_OFS_STATUS 8'h04
`define TTC_OFS_MASK 8'h08
`define TTC_OFS_OUT 8'h0c
`define TTC_OFS_GATE 8'h10
`define TTC_OFS_TPER1 8'h14
`define TTC_OFS_TPER2 8'h18
`define TTC_OFS_TPER3 8'h1c

// ==========================================
// field positions
`define TTC_ST_RX 0
`define TTC_ST_UPD 1
`define TTC_OUT_LATCH 4
`define TTC_OUT_MODE 8

// ==========================================
// reset values
`define TTC_RST_MODE 2'h3
`define TTC_RST_CODE 3'h7

// ==========================================
// times and derived cycle counts
`define TTC_CLK_HZ 25000000
`define TTC_GATE_US 35000
`define TTC_TONE_HZ 801
`define TTC_GATE_CYC ((`TTC_CLK_HZ / 1000000) * `TTC_GATE_US)
`define TTC_TPER_CYC ((`TTC_CLK_HZ + `TTC_TONE_HZ - 1) / `TTC_TONE_HZ)

`endif

// >>> design/ttc_pkg.sv
// types shared by the three-tone code decoder modules
// assumes ttc_map.svh supplies all numeric constants
package ttc_pkg;

   typedef logic [1:0] ttc_tone_t;
   typedef logic [2:0] ttc_code_t;

   typedef enum logic [1:0]
   {
      TTC_M_RESET = 2'b00,
      TTC_M_HOLD = 2'b01,
      TTC_M_NEXT = 2'b10,
      TTC_M_UPDATE = 2'b11
   } ttc_mode_t;

   typedef enum logic [1:0]
   {
      TTC_S_IDLE = 2'b00,
      TTC_S_ONE = 2'b01,
      TTC_S_TWO = 2'b10
   } ttc_seq_t;

endpackage

// >>> design/ttc_code_if.sv
// carrier between tone sequence collector and output/strobe logic
// assumes both ends share one clock
`timescale 1ns/100ps
interface ttc_code_if;
   import ttc_pkg::*;
   logic code_valid;
   ttc_code_t code;
   ttc_tone_t tone3;
   logic [23:0] gate_len;

   modport src
   (
      output code_valid,
      output code,
      output tone3,
      input gate_len
   );
   modport snk
   (
      input code_valid,
      input code,
      input tone3,
      output gate_len
   );
endinterface

// >>> design/ttc_seq_collect.sv
// collects three tone symbols inside the gating period and decodes them
// assumes tone_i is synchronous: 0 silence, 1..3 the programmed tones
`timescale 1ns/100ps
module ttc_seq_collect
(
   input wire logic ref_clk_i,
   input wire logic nrst_i,
   input wire ttc_pkg::ttc_tone_t tone_i,
   ttc_code_if.src cif
);
   import ttc_pkg::*;

   ttc_seq_t state;
   ttc_tone_t last_tone;
   ttc_tone_t t1;
   ttc_tone_t t2;
   logic [23:0] timer;
   logic new_tone;
   logic [3:0] lut;

   // ==========================================
   // sequence table, bit 3 marks a legal code
   function automatic logic [3:0] ttc_lookup(input logic [5:0] seq);
      unique case (seq)
         6'b01_10_01: ttc_lookup = 4'h8;
         6'b11_10_01: ttc_lookup = 4'h9;
         6'b11_01_10: ttc_lookup = 4'ha;
         6'b10_11_01: ttc_lookup = 4'hb;
         6'b10_11_10: ttc_lookup = 4'hc;
         6'b01_11_10: ttc_lookup = 4'hd;
         6'b10_01_11: ttc_lookup = 4'he;
         6'b01_10_11: ttc_lookup = 4'hf;
         default: ttc_lookup = 4'h0;
      endcase
   endfunction

   // a held tone counts once; consecutive tones must differ
   assign new_tone = (tone_i != 2'h0) && (tone_i != last_tone);
   assign lut = ttc_lookup({t1, t2, tone_i});

   // ==========================================
   // tone edge tracking
   always_ff @(posedge ref_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         last_tone <= 2'h0;
      else if (tone_i != 2'h0)
         last_tone <= tone_i;
      else if (state == TTC_S_IDLE)
         last_tone <= 2'h0;
   end

   // ==========================================
   // sequence state; silent gaps allowed while the gate runs
   always_ff @(posedge ref_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         state <= TTC_S_IDLE;
         t1 <= 2'h0;
         t2 <= 2'h0;
         timer <= 24'h0;
      end
      else
      begin
         unique case (state)
            TTC_S_IDLE:
               if (new_tone)
               begin
                  t1 <= tone_i;
                  timer <= cif.gate_len;
                  state <= TTC_S_ONE;
               end
            TTC_S_ONE:
               if (timer == 24'h0)
                  state <= TTC_S_IDLE;
               else
               begin
                  timer <= timer - 24'h1;
                  if (new_tone)
                  begin
                     t2 <= tone_i;
                     state <= TTC_S_TWO;
                  end
               end
            TTC_S_TWO:
               if (timer == 24'h0)
                  state <= TTC_S_IDLE;
               else
               begin
                  timer <= timer - 24'h1;
                  if (new_tone)
                     state <= TTC_S_IDLE;
               end
            default:
               state <= TTC_S_IDLE;
         endcase
      end
   end

   // ==========================================
   // decoded code pulse; unlisted sequences vanish here
   always_ff @(posedge ref_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         cif.code_valid <= 1'b0;
         cif.code <= 3'h0;
         cif.tone3 <= 2'h0;
      end
      else
      begin
         cif.code_valid <= (state == TTC_S_TWO) && (timer != 24'h0) && new_tone
            && lut[3];
         if ((state == TTC_S_TWO) && new_tone && lut[3])
         begin
            cif.code <= lut[2:0];
            cif.tone3 <= tone_i;
         end
      end
   end

endmodule

// >>> tb/ttc_tone_src.sv
// remote three-tone sender model, drives tone symbols at the decoder
// assumes each tone held HOLD cycles and silence between codes
`timescale 1ns/100ps
module ttc_tone_src
#(
   parameter int HOLD = 4
)
(
   input wire logic ref_clk_i,
   output ttc_pkg::ttc_tone_t tone_o
);
   import ttc_pkg::*;
   initial tone_o = 2'h0;
   // ==========
   // one code, optional silent gap after each tone
   task automatic send(input ttc_tone_t a, input ttc_tone_t b, input ttc_tone_t c, input int gap);
      ttc_tone_t seq [3];
      seq = '{a, b, c};
      for (int i = 0; i < 3; i++)
      begin
         repeat (HOLD) @(posedge ref_clk_i) tone_o <= seq[i];
         repeat (gap) @(posedge ref_clk_i) tone_o <= 2'h0;
      end
      @(posedge ref_clk_i) tone_o <= 2'h0;
   endtask
endmodule

// >>> tb/ttc_decoder_props_props.sv
// port checker of the three-tone code decoder, bound to its top
// assumes tone periods left at their defaults
`timescale 1ns/100ps
module ttc_decoder_props
#(
   parameter logic [15:0] TPER_CYC = 16'h0004
)
(
   input wire logic ref_clk_i,
   input wire logic nrst_i,
   input wire ttc_pkg::ttc_tone_t tone_i,
   input wire logic mode1_i,
   input wire logic mode2_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pready_o,
   input wire ttc_pkg::ttc_code_t code_o,
   input wire logic code_rx_n_o
);
   import ttc_pkg::*;
   logic [16:0] low_cnt;
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!nrst_i);
   // ==========
   // strobe length counter
   always_ff @(posedge ref_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         low_cnt <= 17'h0;
      else if (!code_rx_n_o)
         low_cnt <= low_cnt + 17'h1;
      else
         low_cnt <= 17'h0;
   end
   sequence s_setup;
      psel_i && !penable_i;
   endsequence
   sequence s_access;
      psel_i && penable_i;
   endsequence
   a_apb_answer: assert property (s_setup ##1 s_access |=> pready_o)
      else $error("no answer after access");
   a_ready_single: assert property (pready_o |=> !pready_o)
      else $error("ready longer than one cycle");
   a_strobe_width: assert property ($rose(code_rx_n_o) |-> low_cnt == 17'(2 * TPER_CYC))
      else $error("strobe width wrong");
   a_strobe_cause: assert property ($fell(code_rx_n_o) |-> $past(tone_i, 2) != 2'h0)
      else $error("strobe without third tone");
   a_update_edge: assert property ($changed(code_o) |-> $rose(code_rx_n_o) || code_o == 3'h7)
      else $error("code changed off strobe end");
   a_force_ones: assert property ((!mode1_i && !mode2_i) [*4] |-> code_o == 3'h7)
      else $error("reset mode not showing ones");
   a_freeze_hold: assert property ((!mode1_i && mode2_i) [*3] |-> $stable(code_o))
      else $error("code moved while latched");
   a_reset_state: assert property ($rose(nrst_i) |-> code_o == 3'h7 && code_rx_n_o)
      else $error("wrong state after reset");
endmodule

bind ttc_decoder ttc_decoder_props #(.TPER_CYC(TPER_CYC)) ttc_decoder_props_i
(
   .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .tone_i(tone_i), .mode1_i(mode1_i),
   .mode2_i(mode2_i), .psel_i(psel_i), .penable_i(penable_i), .pready_o(pready_o),
   .code_o(code_o), .code_rx_n_o(code_rx_n_o)
);

// >>> tb/testbench.sv
// self-checking bench of the three-tone code decoder
// assumes short tone periods and a gating period written over apb
`timescale 1ns/100ps
module testbench;
   import ttc_pkg::*;
   logic ref_clk_i, nrst_i, mode1_i, mode2_i, psel_i, penable_i, pwrite_i, err;
   logic pready_o, pslverr_o, code_rx_n_o, irq_o;
   logic [7:0] paddr_i;
   logic [31:0] pwdata_i, prdata_o, rd;
   ttc_tone_t tone_i;
   ttc_code_t code_o;
   int n_errors = 0;
   int num_checks = 0;
   // tone triples per code 0..7, first tone in the top bits
   logic [5:0] seqs [8] = '{6'h19, 6'h39, 6'h36, 6'h2d, 6'h2e, 6'h1e, 6'h27, 6'h1b};
   ttc_decoder #(.TPER_CYC(16'h0004)) ttc_decoder_i
   (
      .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .tone_i(tone_i), .mode1_i(mode1_i),
      .mode2_i(mode2_i), .paddr_i(paddr_i), .psel_i(psel_i), .penable_i(penable_i),
      .pwrite_i(pwrite_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
      .pslverr_o(pslverr_o), .code_o(code_o), .code_rx_n_o(code_rx_n_o), .irq_o(irq_o)
   );
   ttc_tone_src ttc_tone_src_i (.ref_clk_i(ref_clk_i), .tone_o(tone_i));
   initial
   begin
      ref_clk_i = 1'b0;
      forever #20 ref_clk_i = ~ref_clk_i;
   end
   // ==========
   // checks and verdict
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic conclude();
      $display("checks=%0d errors=%0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // ==========
   // apb master: hold request until ready seen at a rising edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge ref_clk_i);
      psel_i <= 1'b1;
      pwrite_i <= wr;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge ref_clk_i);
      penable_i <= 1'b1;
      n = 0;
      // ready, data and error are taken at the edge where ready is sampled high
      do
      begin
         @(posedge ref_clk_i);
         n++;
      end
      while (pready_o !== 1'b1 && n < 20);
      if (n >= 20)
      begin
         n_errors++;
         conclude();
      end
      rd = prdata_o;
      err = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
   endtask
   // one code from the far side, then strobe and output compared
   task automatic code(input logic [5:0] s, input int gap, input logic stb, input ttc_code_t exp);
      int n;
      ttc_tone_src_i.send(s[5:4], s[3:2], s[1:0], gap);
      #1;
      n = 0;
      while (code_rx_n_o !== 1'b0 && n < 40)
      begin
         @(posedge ref_clk_i);
         #1;
         n++;
      end
      chk(32'(n < 40), 32'(stb));
      n = 0;
      while (code_rx_n_o === 1'b0 && n < 40)
      begin
         @(posedge ref_clk_i);
         #1;
         n++;
      end
      // a strobe stuck low uses up the bound and counts as a mismatch
      if (n >= 40)
         n_errors++;
      chk(32'(code_o), 32'(exp));
   endtask
   task automatic set_mode(input logic m1, input logic m2);
      @(posedge ref_clk_i);
      mode1_i <= m1;
      mode2_i <= m2;
   endtask
   // ==========
   // main sequence
   initial
   begin
      nrst_i = 1'b0;
      mode1_i = 1'b1;
      mode2_i = 1'b1;
      psel_i = 1'b0;
      penable_i = 1'b0;
      pwrite_i = 1'b0;
      paddr_i = 8'h00;
      pwdata_i = 32'h0;
      repeat (12) @(posedge ref_clk_i);
      chk(32'(code_o), 32'h7);
      chk(32'(code_rx_n_o), 32'h1);
      nrst_i <= 1'b1;
      repeat (3) @(posedge ref_clk_i);
      apb(1'b1, 8'h10, 32'hc8);
      apb(1'b0, 8'h0c, 32'h0);
      chk(rd, 32'h307);
      apb(1'b0, 8'h20, 32'h0);
      chk(32'(err), 32'h1);
      apb(1'b1, 8'h08, 32'h1);
      for (int i = 0; i < 8; i++)
         code(seqs[i], 0, 1'b1, ttc_code_t'(i));
      apb(1'b0, 8'h04, 32'h0);
      chk(rd, 32'h3);
      chk(32'(irq_o), 32'h1);
      apb(1'b1, 8'h04, 32'h3);
      apb(1'b1, 8'h08, 32'h0);
      chk(32'(irq_o), 32'h0);
      code(seqs[7], 0, 1'b1, 3'h7);
      code(6'h1d, 0, 1'b0, 3'h7);
      code(seqs[0], 3, 1'b1, 3'h0);
      set_mode(1'b0, 1'b1);
      code(seqs[5], 0, 1'b1, 3'h0);
      set_mode(1'b1, 1'b0);
      code(seqs[3], 0, 1'b1, 3'h3);
      code(seqs[4], 0, 1'b1, 3'h3);
      apb(1'b0, 8'h0c, 32'h0);
      chk(rd, 32'h213);
      set_mode(1'b0, 1'b0);
      repeat (4) @(posedge ref_clk_i);
      #1;
      chk(32'(code_o), 32'h7);
      code(seqs[2], 0, 1'b1, 3'h7);
      set_mode(1'b1, 1'b1);
      code(seqs[2], 0, 1'b1, 3'h2);
      conclude();
   end
endmodule
